// ==== rtl/fpsc_pkg.sv ====
// Behaviour
// - Bit 24 of live register: 0 full IEEE operation, 1 flush denormals to zero.
// - Bits 23:22 decode 00 nearest, 01 plus inf, 10 minus inf, 11 zero.
// - Instructions take rounding from the programmed field, not a fixed mode.
// - Exception flags set on event and stay set until software writes 0; a new context or a 1 written to interrupt status also clears them.
// - Flags: input denormal 7, inexact 4, underflow 3, overflow 2, divzero 1, invalid 0.
// - New floating-point context copies default control values into live register.
// - Default register holds bits 26, 25, 24 and 23:22; other bits reserved.
// - With security extension the default register has Secure and Non-secure copies.
// - Unit leaves reset disabled; instructions unusable until access enabled.
// - Access control register is read and written only in privileged mode.
// - Bit 26: 0 IEEE half precision, 1 alternative half precision.
// - Bit 25: 0 NaNs propagate, 1 operations with NaN return default NaN.
// - Comparisons update condition flags in bits 31:28 of live register.
// - Live register is a single copy shared by both security states.
package fpsc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
	localparam logic [3:0] ADDR_DEFAULT_S = 4'h1;
	localparam logic [3:0] ADDR_DEFAULT_NS = 4'h2;
	localparam logic [3:0] ADDR_ACCESS_CTRL = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
	localparam logic [3:0] ADDR_UNIT_STATE = 4'h6;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int COND_HI = 31;
	localparam int COND_LO = 28;
	localparam int AHP_BIT = 26;
	localparam int DN_BIT = 25;
	localparam int FZ_BIT = 24;
	localparam int RND_HI = 23;
	localparam int RND_LO = 22;
	localparam int IDC_BIT = 7;
	localparam int FLAGS_HI = 4;
	localparam int CP_HI = 23;
	localparam int CP_LO = 20;

	localparam logic [31:0] LIVE_MASK = 32'hF7C0_009F;
	localparam logic [31:0] DEFAULT_MASK = 32'h07C0_0000;
	localparam logic [31:0] ACCESS_MASK = 32'h00F0_0000;
	localparam logic [31:0] LIVE_RESET = 32'h0000_0000;
	localparam logic [31:0] DEFAULT_RESET = 32'h0000_0000;
	localparam logic [31:0] ACCESS_RESET = 32'h0000_0000;
	localparam logic [3:0] CP_FULL = 4'hF;
	localparam logic [7:0] FLAG_MASK = 8'h9F;

	typedef enum logic [1:0] {
		FPSC_RN = 2'b00,
		FPSC_RP = 2'b01,
		FPSC_RM = 2'b10,
		FPSC_RZ = 2'b11
	} fpsc_round_t;

endpackage

// ==== rtl/fpsc_flag_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface fpsc_flag_if;
	logic [7:0] raise;
	logic [7:0] clear;
	logic [7:0] flags;
	modport owner(input raise, input clear, output flags);
	modport user(output raise, output clear, input flags);
endinterface
`default_nettype wire

// ==== rtl/fpsc_sticky_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpsc_sticky_flags
	import fpsc_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	fpsc_flag_if.owner fl
);
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;

	// Set wins over clear so an event in the clearing cycle is kept.
	always_comb begin
		flags_nxt = ((flags_r & ~fl.clear) | fl.raise) & FLAG_MASK;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flags_r <= 8'h00;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign fl.flags = flags_r;

	a_flag_sticky: assert property (@(posedge mclk) disable iff (!resetn)
		(flags_r[0] && !fl.clear[0]) |=> flags_r[0])
		else $error("sticky flag dropped without clear");
	a_flag_reserved: assert property (@(posedge mclk) disable iff (!resetn)
		(flags_r & ~FLAG_MASK) == 8'h00)
		else $error("flag set in reserved position");
endmodule
`default_nettype wire

// ==== rtl/fpsc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpsc_regs
	import fpsc_pkg::*;
#(
	parameter bit HAS_SECURITY = 1'b1
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic reg_priv,
	input wire logic reg_secure,
	output logic [31:0] reg_rdata,
	input wire logic new_context,
	input wire logic context_secure,
	input wire logic cmp_valid,
	input wire logic [3:0] cmp_nzcv,
	input wire logic [7:0] exc_raise,
	output logic fpu_enabled,
	output logic flush_to_zero,
	output logic [1:0] rounding_select,
	output logic alt_half_precision,
	output logic default_nan_mode,
	output logic irq
);
	// ----------------------------------------------------------------
	// Live and default registers
	// ----------------------------------------------------------------
	logic [31:0] live_r, live_nxt;
	logic [31:0] dflt_s_r, dflt_s_nxt;
	logic [31:0] dflt_ns_r, dflt_ns_nxt;
	logic [31:0] access_r, access_nxt;
	logic [7:0] mask_r, mask_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic enabled_r, irq_r;
	logic [7:0] flag_clear;
	logic [7:0] flag_set_ev;
	logic wr_live, wr_irq;

	fpsc_flag_if fl ();

	assign wr_live = reg_write && reg_addr == ADDR_STATUS_CTRL;
	assign wr_irq = reg_write && reg_addr == ADDR_IRQ_STATUS;

	// ----------------------------------------------------------------
	// Sticky flag control
	// ----------------------------------------------------------------
	// Writing 0 to a flag clears it; a new context clears all flags.
	// A write of one to the interrupt status clears the same storage,
	// so the two views of the flags can never drift apart.
	always_comb begin
		flag_clear = 8'h00;
		if (new_context) begin
			flag_clear = 8'hFF;
		end else if (wr_live) begin
			flag_clear = ~reg_wdata[7:0];
		end else if (wr_irq) begin
			flag_clear = reg_wdata[7:0];
		end
	end

	// A new context beats a software write, so the write data must not
	// set flags in that cycle; a raised exception still does.
	always_comb begin
		flag_set_ev = exc_raise & FLAG_MASK;
		if (wr_live && !new_context) begin
			flag_set_ev = flag_set_ev | (reg_wdata[7:0] & FLAG_MASK);
		end
	end

	assign fl.raise = flag_set_ev;
	assign fl.clear = flag_clear;

	fpsc_sticky_flags u_flags (
		.mclk(mclk),
		.resetn(resetn),
		.fl(fl)
	);

	// ----------------------------------------------------------------
	// Live register
	// ----------------------------------------------------------------
	// One copy serves both security states. The flag byte lives in the
	// sticky module, so it is held at 0 here and merged only on reads.
	always_comb begin
		live_nxt = live_r;
		if (new_context) begin
			live_nxt = (context_secure ? dflt_s_r : dflt_ns_r) & DEFAULT_MASK;
		end else if (wr_live) begin
			live_nxt = reg_wdata & LIVE_MASK;
		end
		if (cmp_valid) begin
			live_nxt[COND_HI:COND_LO] = cmp_nzcv;
		end
		live_nxt[7:0] = 8'h00;
	end

	// ----------------------------------------------------------------
	// Default control copies
	// ----------------------------------------------------------------
	// Without the security extension only the secure index writes the one copy; both indices read it.
	always_comb begin
		dflt_s_nxt = dflt_s_r;
		dflt_ns_nxt = dflt_ns_r;
		if (reg_write && reg_priv) begin
			if (reg_addr == ADDR_DEFAULT_S && (reg_secure || !HAS_SECURITY)) begin
				dflt_s_nxt = reg_wdata & DEFAULT_MASK;
			end
			if (reg_addr == ADDR_DEFAULT_NS && HAS_SECURITY) begin
				dflt_ns_nxt = reg_wdata & DEFAULT_MASK;
			end
		end
		if (!HAS_SECURITY) begin
			dflt_ns_nxt = dflt_s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Access control
	// ----------------------------------------------------------------
	// Unprivileged writes to the access control are ignored.
	always_comb begin
		access_nxt = access_r;
		if (reg_write && reg_priv && reg_addr == ADDR_ACCESS_CTRL) begin
			access_nxt = reg_wdata & ACCESS_MASK;
		end
	end

	always_comb begin
		mask_nxt = mask_r;
		if (reg_write && reg_addr == ADDR_IRQ_MASK) begin
			mask_nxt = reg_wdata[7:0] & FLAG_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_read) begin
			unique case (reg_addr)
				ADDR_STATUS_CTRL: rdata_nxt = live_r | {24'h00_0000, fl.flags};
				ADDR_DEFAULT_S: begin
					if (reg_secure || !HAS_SECURITY) begin
						rdata_nxt = dflt_s_r;
					end
				end
				ADDR_DEFAULT_NS: rdata_nxt = dflt_ns_r;
				ADDR_ACCESS_CTRL: begin
					if (reg_priv) begin
						rdata_nxt = access_r;
					end
				end
				ADDR_IRQ_STATUS: rdata_nxt = {24'h00_0000, fl.flags};
				ADDR_IRQ_MASK: rdata_nxt = {24'h00_0000, mask_r};
				ADDR_UNIT_STATE: rdata_nxt = {31'h0000_0000, enabled_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and registered outputs
	// ----------------------------------------------------------------
	// The interrupt follows the flags one cycle late; bits being cleared
	// through the interrupt status are masked here so the line drops together with the flag.
	logic [7:0] irq_clr;
	assign irq_clr = wr_irq ? reg_wdata[7:0] : 8'h00;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			live_r <= LIVE_RESET;
			dflt_s_r <= DEFAULT_RESET;
			dflt_ns_r <= DEFAULT_RESET;
			access_r <= ACCESS_RESET;
			mask_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
			enabled_r <= 1'b0;
			irq_r <= 1'b0;
			flush_to_zero <= 1'b0;
			rounding_select <= FPSC_RN;
			alt_half_precision <= 1'b0;
			default_nan_mode <= 1'b0;
		end else begin
			live_r <= live_nxt;
			dflt_s_r <= dflt_s_nxt;
			dflt_ns_r <= dflt_ns_nxt;
			access_r <= access_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
			enabled_r <= access_nxt[CP_HI:CP_LO] == CP_FULL;
			irq_r <= |(fl.flags & mask_r & ~irq_clr);
			flush_to_zero <= live_nxt[FZ_BIT];
			rounding_select <= live_nxt[RND_HI:RND_LO];
			alt_half_precision <= live_nxt[AHP_BIT];
			default_nan_mode <= live_nxt[DN_BIT];
		end
	end

	assign reg_rdata = rdata_r;
	assign fpu_enabled = enabled_r;
	assign irq = irq_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_ctx_load;
		new_context && !wr_live;
	endsequence

	a_ctx_copy: assert property (@(posedge mclk) disable iff (!resetn)
		s_ctx_load ##0 !cmp_valid |=> live_r ==
			(($past(context_secure) ? $past(dflt_s_r) : $past(dflt_ns_r))
			& DEFAULT_MASK))
		else $error("new context did not load defaults");
	a_round_out: assert property (@(posedge mclk) disable iff (!resetn)
		rounding_select == live_r[RND_HI:RND_LO])
		else $error("rounding output differs from register");
	a_ftz_out: assert property (@(posedge mclk) disable iff (!resetn)
		flush_to_zero == live_r[FZ_BIT])
		else $error("flush to zero output differs from register");
	a_live_resv: assert property (@(posedge mclk) disable iff (!resetn)
		(live_r & ~LIVE_MASK) == 32'h0000_0000)
		else $error("reserved live bit set");
	a_dflt_resv: assert property (@(posedge mclk) disable iff (!resetn)
		((dflt_s_r | dflt_ns_r) & ~DEFAULT_MASK) == 32'h0000_0000)
		else $error("reserved default bit set");
	a_unpriv_ignored: assert property (@(posedge mclk) disable iff (!resetn)
		reg_write && !reg_priv |=> $stable(access_r))
		else $error("unprivileged write changed access control");
	a_enable_tie: assert property (@(posedge mclk) disable iff (!resetn)
		fpu_enabled == (access_r[CP_HI:CP_LO] == CP_FULL))
		else $error("enable does not follow access bits");
	a_cond_update: assert property (@(posedge mclk) disable iff (!resetn)
		cmp_valid |=> live_r[COND_HI:COND_LO] == $past(cmp_nzcv))
		else $error("comparison flags not stored");
	a_read_timing: assert property (@(posedge mclk) disable iff (!resetn)
		!reg_read |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");

	sequence s_live_wr;
		wr_live && !new_context && !cmp_valid;
	endsequence

	sequence s_irq_pending;
		(fl.flags & mask_r) != 8'h00;
	endsequence

	a_live_write: assert property (@(posedge mclk)
		disable iff (!resetn) s_live_wr |=> live_r ==
			($past(reg_wdata) & LIVE_MASK & 32'hFFFF_FF00))
		else $error("live write not stored");
	a_ahp_out: assert property (@(posedge mclk)
		disable iff (!resetn) alt_half_precision == live_r[AHP_BIT])
		else $error("half precision output differs from register");
	a_dn_out: assert property (@(posedge mclk)
		disable iff (!resetn) default_nan_mode == live_r[DN_BIT])
		else $error("default NaN output differs from register");
	a_round_hold: assert property (@(posedge mclk)
		disable iff (!resetn)
		!wr_live && !new_context |=> $stable(rounding_select))
		else $error("rounding changed without a write");
	a_flag_set: assert property (@(posedge mclk)
		disable iff (!resetn) flag_set_ev != 8'h00 |=>
			(fl.flags & $past(flag_set_ev)) == $past(flag_set_ev))
		else $error("raised flag not stored");
	a_flag_clear: assert property (@(posedge mclk)
		disable iff (!resetn) s_live_wr ##0 exc_raise == 8'h00 |=>
			{24'h00_0000, fl.flags} ==
			($past(reg_wdata) & {24'h00_0000, FLAG_MASK}))
		else $error("flags do not follow written value");
	a_ctx_flags: assert property (@(posedge mclk)
		disable iff (!resetn) new_context && exc_raise == 8'h00 |=>
			fl.flags == 8'h00)
		else $error("new context left flags set");
	a_irq_set: assert property (@(posedge mclk)
		disable iff (!resetn) s_irq_pending ##0 !wr_irq |=> irq)
		else $error("unmasked flag did not raise interrupt");
	a_irq_clear: assert property (@(posedge mclk)
		disable iff (!resetn) (fl.flags & mask_r) == 8'h00 |=> !irq)
		else $error("interrupt high without unmasked flag");
	a_access_read: assert property (@(posedge mclk)
		disable iff (!resetn)
		reg_read && !reg_priv && reg_addr == ADDR_ACCESS_CTRL |=>
			reg_rdata == 32'h0000_0000)
		else $error("unprivileged read saw access control");
	a_unmapped_read: assert property (@(posedge mclk)
		disable iff (!resetn)
		reg_read && reg_addr > ADDR_UNIT_STATE |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped index read nonzero");
	a_dflt_s_guard: assert property (@(posedge mclk)
		disable iff (!resetn) HAS_SECURITY && reg_write && !reg_secure &&
			reg_addr == ADDR_DEFAULT_S |=> $stable(dflt_s_r))
		else $error("non-secure write reached secure defaults");
	a_dflt_s_write: assert property (@(posedge mclk)
		disable iff (!resetn) reg_write && reg_priv && reg_secure &&
			reg_addr == ADDR_DEFAULT_S |=>
			dflt_s_r == ($past(reg_wdata) & DEFAULT_MASK))
		else $error("secure default write not stored");
	a_dflt_ns_write: assert property (@(posedge mclk)
		disable iff (!resetn) HAS_SECURITY && reg_write && reg_priv &&
			reg_addr == ADDR_DEFAULT_NS |=>
			dflt_ns_r == ($past(reg_wdata) & DEFAULT_MASK))
		else $error("non-secure default write not stored");
	a_access_resv: assert property (@(posedge mclk)
		disable iff (!resetn) (access_r & ~ACCESS_MASK) == 32'h0000_0000)
		else $error("reserved access bit set");
endmodule
`default_nettype wire

// ==== verif/fpsc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpsc_core_model
	import fpsc_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [1:0] op,
	input wire logic [7:0] arg,
	output logic new_context,
	output logic context_secure,
	output logic cmp_valid,
	output logic [3:0] cmp_nzcv,
	output logic [7:0] exc_raise
);
	// Each retired instruction shows as a single-cycle pulse, as a pipeline
	// that never stalls would present it.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			{new_context, context_secure, cmp_valid, cmp_nzcv, exc_raise} <= '0;
		end else begin
			new_context <= (op == 2'd1);
			context_secure <= arg[0];
			cmp_valid <= (op == 2'd2);
			cmp_nzcv <= arg[3:0];
			exc_raise <= (op == 2'd3) ? (arg & FLAG_MASK) : 8'h00;
		end
	end
endmodule
`default_nettype wire

// ==== verif/tb_fp_status_control_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_fp_status_control_regs;
	import fpsc_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rdv, d, ds;
	logic reg_write, reg_read, reg_priv, reg_secure;
	logic [1:0] op, rounding_select;
	logic [7:0] arg, exc_raise;
	logic new_context, context_secure, cmp_valid, fpu_enabled, irq;
	logic flush_to_zero, alt_half_precision, default_nan_mode;
	logic [3:0] cmp_nzcv;
	int error_cnt = 0;
	int compares = 0;
	int seed = 43;
	int fb[6] = '{7, 4, 3, 2, 1, 0};
	// Reference state kept from the rules alone; index 0 holds the live
	// word with its flags in the low byte.
	int m_reg[8] = '{default: 0};

	function automatic logic [31:0] mdl(input logic [3:0] a, input logic p,
		input logic s);
		case (a)
			ADDR_DEFAULT_S: return s ? m_reg[1] : 0;
			ADDR_ACCESS_CTRL: return p ? m_reg[3] : 0;
			ADDR_IRQ_STATUS: return m_reg[0] & 32'h0000_009F;
			default: return (a < 4'h7) ? m_reg[a] : 0;
		endcase
	endfunction

	fpsc_regs i_dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_priv, .reg_secure, .reg_rdata, .new_context,
		.context_secure, .cmp_valid, .cmp_nzcv, .exc_raise, .fpu_enabled,
		.flush_to_zero, .rounding_select, .alt_half_precision,
		.default_nan_mode, .irq);
	fpsc_core_model i_core (.mclk, .resetn, .op, .arg, .new_context,
		.context_secure, .cmp_valid, .cmp_nzcv, .exc_raise);

	always #2.5 mclk = ~mclk;

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Bus and core drivers
	// ----------------------------------------------------------------
	// Strobes drop at the next edge, so no signal is assigned twice in a step.
	task automatic wr(input logic [3:0] a, input logic [31:0] v,
		input logic p, input logic s);
		@(posedge mclk);
		{reg_addr, reg_wdata, reg_priv, reg_secure, reg_write} <= {a, v, p, s, 1'b1};
		@(posedge mclk);
		reg_write <= 1'b0;
		case (a)
			ADDR_STATUS_CTRL: m_reg[0] = v & LIVE_MASK;
			ADDR_DEFAULT_S: if (p && s) m_reg[1] = v & DEFAULT_MASK;
			ADDR_DEFAULT_NS: if (p) m_reg[2] = v & DEFAULT_MASK;
			ADDR_ACCESS_CTRL: if (p) m_reg[3] = v & ACCESS_MASK;
			ADDR_IRQ_STATUS: m_reg[0] = m_reg[0] & ~(v & 32'h0000_00FF);
			ADDR_IRQ_MASK: m_reg[5] = v & 32'h0000_009F;
			default: ;
		endcase
		m_reg[6] = (m_reg[3] == ACCESS_MASK);
	endtask

	task automatic rd(input logic [3:0] a, input logic p, input logic s,
		input logic [31:0] m, input logic [31:0] e);
		@(posedge mclk);
		{reg_addr, reg_priv, reg_secure, reg_read} <= {a, p, s, 1'b1};
		@(posedge mclk);
		reg_read <= 1'b0;
		#1;
		rdv = reg_rdata;
		chk("rdata", e, rdv & m);
		chk("model", mdl(a, p, s) & m, rdv & m);
	endtask

	task automatic core(input logic [1:0] o, input logic [7:0] v);
		@(posedge mclk);
		{op, arg} <= {o, v};
		@(posedge mclk);
		{op, arg} <= '0;
		@(posedge mclk);
		case (o)
			2'd1: m_reg[0] = m_reg[v[0] ? 1 : 2] & DEFAULT_MASK;
			2'd2: m_reg[0] = (m_reg[0] & 32'h0FFF_FFFF) | (32'(v[3:0]) << 28);
			2'd3: m_reg[0] = m_reg[0] | (v & 8'h9F);
			default: ;
		endcase
	endtask

	initial begin
		#20us;
		error_cnt++;
		$display("[ERR] watchdog expected done seen hang");
		conclude();
	end

	initial begin
		{reg_addr, reg_wdata, reg_write, reg_read, reg_priv, reg_secure} = '0;
		{op, arg} = '0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		chk("enabled", 32'h0, 32'(fpu_enabled));
		for (int a = 0; a < 8; a++) rd(a[3:0], 1, 1, '1, 0);
		$display("test reset done");
		wr(ADDR_ACCESS_CTRL, ACCESS_MASK, 0, 1);
		rd(ADDR_ACCESS_CTRL, 1, 1, '1, 0);
		wr(ADDR_DEFAULT_NS, 32'h0000_0000, 1, 1);
		wr(ADDR_ACCESS_CTRL, rdv | {8'h00, CP_FULL, 20'h0_0000}, 1, 1);
		repeat (2) @(posedge mclk);
		chk("enabled", 32'h1, 32'(fpu_enabled));
		rd(ADDR_UNIT_STATE, 1, 1, 32'h0000_0001, 32'h1);
		rd(ADDR_ACCESS_CTRL, 0, 1, '1, 0);
		rd(ADDR_ACCESS_CTRL, 1, 0, '1, ACCESS_MASK);
		$display("test access done");
		for (int i = 0; i < 4; i++) begin
			d = ($random(seed) & 32'hFF3F_FFFF) | (32'(i) << 22);
			wr(ADDR_STATUS_CTRL, d, i[0], i[1]);
			rd(ADDR_STATUS_CTRL, 1, ~i[1], '1, d & LIVE_MASK);
			chk("ctl", {27'h0, d[26:22]}, {27'h0, alt_half_precision,
				default_nan_mode, flush_to_zero, rounding_select});
		end
		$display("test live done");
		wr(ADDR_STATUS_CTRL, 0, 1, 1);
		wr(ADDR_IRQ_MASK, 32'h0000_0004, 1, 1);
		foreach (fb[k]) begin
			core(2'd3, 8'(1 << fb[k]));
			rd(ADDR_STATUS_CTRL, 1, 1, 32'h0000_00FF, 32'(1 << fb[k]));
			rd(ADDR_STATUS_CTRL, 1, 1, 32'h0000_00FF, 32'(1 << fb[k]));
			chk("irq", 32'(fb[k] == 2), 32'(irq));
			wr(ADDR_STATUS_CTRL, 0, 1, 1);
			rd(ADDR_STATUS_CTRL, 1, 1, 32'h0000_00FF, 0);
		end
		core(2'd3, 8'h04);
		wr(ADDR_IRQ_STATUS, 32'h0000_0004, 1, 1);
		rd(ADDR_IRQ_STATUS, 1, 1, 32'h0000_00FF, 0);
		chk("irq", 32'h0, 32'(irq));
		$display("test flags done");
		ds = $random(seed);
		wr(ADDR_DEFAULT_S, ~ds, 1, 0);
		wr(ADDR_DEFAULT_S, ds, 1, 1);
		wr(ADDR_DEFAULT_NS, ~ds, 1, 0);
		rd(ADDR_DEFAULT_S, 1, 0, '1, 0);
		rd(ADDR_DEFAULT_S, 1, 1, '1, ds & DEFAULT_MASK);
		rd(ADDR_DEFAULT_NS, 1, 0, '1, ~ds & DEFAULT_MASK);
		for (int s = 0; s < 2; s++) begin
			core(2'd3, 8'h9F);
			core(2'd1, 8'(s));
			d = s ? ds : ~ds;
			rd(ADDR_STATUS_CTRL, 1, 1, 32'h07C0_009F, d & DEFAULT_MASK);
		end
		$display("test defaults done");
		for (int n = 0; n < 16; n++) begin
			core(2'd2, 8'(n));
			rd(ADDR_STATUS_CTRL, 1, 1, 32'hF000_0000, 32'(n) << 28);
		end
		$display("test compare done");
		conclude();
	end
endmodule
`default_nettype wire
